// *** src/ee_pkg.sv ***
// Shared constants and types for the two-wire serial EEPROM link.
// Assumes a 25 MHz system clock on both ends; all timing counts derive from it.
package ee_pkg;

  // ---------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------
  localparam int EE_ADDR_W = 11;
  localparam int EE_DEPTH  = 2048;
  localparam int EE_PAGE_B = 16;
  localparam logic [3:0] EE_DEV_CODE = 4'ha; // Fixed select pattern 1010

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int EE_CLK_NS  = 40;
  localparam int EE_TWR_NS  = 3_000_000;                 // Write cycle, longest
  localparam int EE_TWR_CYC = EE_TWR_NS / EE_CLK_NS;     // Rounds down
  localparam int EE_TLOW_NS = 500;                       // SCL low, least
  // A quarter of an SCL period; two quarters make the low time
  localparam int EE_QTR_CYC = (EE_TLOW_NS / 2 + EE_CLK_NS - 1) / EE_CLK_NS;
  localparam logic [3:0] EE_QTR_LAST = 4'(EE_QTR_CYC - 1);
  localparam logic [3:0] EE_LAST_BIT = 4'h8;             // Ninth clock index

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] EE_SYNC_IDLE = 2'h3;            // Released bus
  localparam logic [10:0] EE_CNT_RST = 11'h000;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    EE_OP_WRITE   = 2'h0,
    EE_OP_RAND_RD = 2'h1,
    EE_OP_CUR_RD  = 2'h2,
    EE_OP_RECOVER = 2'h3
  } ee_op_t;

  typedef enum logic [2:0] {
    EE_SYM_START = 3'h0,
    EE_SYM_STOP  = 3'h1,
    EE_SYM_TX    = 3'h2,
    EE_SYM_RX    = 3'h3,
    EE_SYM_RECOV = 3'h4
  } ee_sym_t;

  typedef enum logic [1:0] {
    EE_D_IDLE = 2'h0,
    EE_D_RX   = 2'h1,
    EE_D_TX   = 2'h3
  } ee_dst_t;

  typedef enum logic [1:0] {
    EE_ROLE_DEV  = 2'h0,
    EE_ROLE_WADR = 2'h1,
    EE_ROLE_DATA = 2'h3
  } ee_role_t;

  typedef enum logic [1:0] {
    EE_M_IDLE = 2'h0,
    EE_M_RUN  = 2'h1,
    EE_M_DONE = 2'h3
  } ee_mst_t;

endpackage

// *** src/ee_link_if.sv ***
// Two-wire link between the bus master and the EEPROM device.
// Assumes open-drain SDA with a pull-up; SCL is driven by the master only.
interface ee_link_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic sda;

  // Wired-AND with pull-up: any enabled low driver wins
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_d_oe & ~sda_d_o));

  modport master (output scl, output sda_m_o, output sda_m_oe, input sda);
  modport device (input scl, input sda, output sda_d_o, output sda_d_oe);
endinterface

// *** src/ee_device.sv ***
// EEPROM device end: start/stop detection, address compare, byte and page
// writes, reads, write protect and the self-timed write cycle.
// Assumes link_clk oversamples SCL/SDA well above the SCL rate, and clock
// runs at 25 MHz for the write-cycle timer.

module ee_device
  import ee_pkg::*;
#(
  parameter int WR_CYCLES = EE_TWR_CYC
) (
  input  wire logic link_clk,
  input  wire logic clock,
  input  wire logic rst_n,
  ee_link_if.device link,
  input  wire logic wp,
  output logic      standby,
  output logic      write_busy
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [1:0]  scl_q;
  logic [1:0]  sda_q;
  logic [1:0]  wp_q;
  logic        scl_p;
  logic        sda_p;
  logic        start_ev;
  logic        stop_ev;
  logic        rise;
  logic        fall;
  logic        sda_s;
  logic [7:0]  byte_in;
  ee_dst_t     st_r;
  ee_role_t    role_r;
  logic [3:0]  bit_r;
  logic [7:0]  sh_r;
  logic [7:0]  tx_r;
  logic [10:0] cnt_r;
  logic        rd_dir_r;
  logic        ack_r;
  logic        oe_r;
  logic [7:0]  mem [EE_DEPTH];
  logic [7:0]  pbuf [EE_PAGE_B];
  logic [15:0] mask_r;
  logic        data_we;
  logic        byte_done;
  logic        commit;
  logic        wbusy_r;
  logic        wr_tgl_r;
  logic [2:0]  done_q;
  logic [2:0]  req_q;
  logic        done_tgl_r;
  logic        tmr_run_r;
  logic [19:0] tmr_r;

  // ---------------------------------------------------------------
  // Pin synchronisers and bus events
  // ---------------------------------------------------------------
  // Two flops per pin, then one more stage on SCL and SDA for edge detection
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= EE_SYNC_IDLE;
      sda_q <= EE_SYNC_IDLE;
      wp_q  <= 2'h0;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_q <= {scl_q[0], link.scl};
      sda_q <= {sda_q[0], link.sda};
      wp_q  <= {wp_q[0], wp};
      scl_p <= scl_q[1];
      sda_p <= sda_q[1];
    end
  end

  assign sda_s = sda_q[1];
  assign start_ev = scl_q[1] & scl_p & sda_p & ~sda_s;
  assign stop_ev  = scl_q[1] & scl_p & ~sda_p & sda_s;
  // other SDA moves during high are only start or stop
  assign rise = scl_q[1] & ~scl_p;
  assign fall = ~scl_q[1] & scl_p;
  assign byte_in   = {sh_r[6:0], sda_s};
  assign byte_done = rise && (st_r == EE_D_RX) && (bit_r == 4'h7);
  assign data_we   = byte_done && (role_r == EE_ROLE_DATA) && !wp_q[1];
  // no stored bytes, no write cycle
  assign commit    = stop_ev && (|mask_r);

  // ---------------------------------------------------------------
  // Protocol engine
  // ---------------------------------------------------------------
  // Start and stop override any bit in flight
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r     <= EE_D_IDLE;
      role_r   <= EE_ROLE_DEV;
      bit_r    <= 4'h0;
      sh_r     <= 8'h00;
      tx_r     <= 8'h00;
      cnt_r    <= EE_CNT_RST;
      rd_dir_r <= 1'b0;
      ack_r    <= 1'b0;
      oe_r     <= 1'b0;
    end else if (start_ev) begin
      st_r   <= EE_D_RX;
      role_r <= EE_ROLE_DEV;
      bit_r  <= 4'h0;
      ack_r  <= 1'b0;
      oe_r   <= 1'b0;
    end else if (stop_ev) begin
      st_r <= EE_D_IDLE;
      oe_r <= 1'b0;
    end else begin
      case (st_r)
        EE_D_RX: begin
          if (rise && bit_r != EE_LAST_BIT) begin
            sh_r  <= byte_in;
            bit_r <= bit_r + 4'h1;
          end else if (rise) begin
            bit_r <= 4'h0;
            ack_r <= 1'b0;
            if (rd_dir_r && role_r == EE_ROLE_WADR) begin
              st_r <= EE_D_TX;
            end
          end
          if (fall) begin
            oe_r <= (bit_r == EE_LAST_BIT) && ack_r;
          end
          if (byte_done) begin
            case (role_r)
              EE_ROLE_DEV: begin
                // select pattern; no ack while busy
                if (byte_in[7:4] == EE_DEV_CODE && !wbusy_r) begin
                  ack_r <= 1'b1;
                  rd_dir_r <= byte_in[0];
                  cnt_r[10:8] <= byte_in[3:1];
                  role_r <= EE_ROLE_WADR;
                end else begin
                  st_r <= EE_D_IDLE;
                end
              end
              EE_ROLE_WADR: begin
                cnt_r[7:0] <= byte_in;
                ack_r      <= 1'b1;
                role_r     <= EE_ROLE_DATA;
              end
              default: begin
                cnt_r[3:0] <= cnt_r[3:0] + 4'h1;
                ack_r      <= 1'b1;
              end
            endcase
          end
        end
        EE_D_TX: begin
          // launch after fall, open drain low only
          if (fall && bit_r == 4'h0) begin
            oe_r <= ~mem[cnt_r][7];
            tx_r <= {mem[cnt_r][6:0], 1'b0};
          end else if (fall && bit_r != EE_LAST_BIT) begin
            oe_r <= ~tx_r[7];
            tx_r <= {tx_r[6:0], 1'b0};
          end else if (fall) begin
            oe_r <= 1'b0;
          end
          if (rise && bit_r != EE_LAST_BIT) begin
            bit_r <= bit_r + 4'h1;
            if (bit_r == 4'h7) begin
              cnt_r <= cnt_r + 11'h001;
            end
          end else if (rise) begin
            bit_r <= 4'h0;
            // master ack continues; no ack ends
            if (sda_s) begin
              st_r <= EE_D_IDLE;
            end
          end
        end
        default: begin
          oe_r <= 1'b0;
        end
      endcase
    end
  end

  assign link.sda_d_oe = oe_r;
  assign link.sda_d_o  = 1'b0; // Never drives high

  // ---------------------------------------------------------------
  // Page buffer and array
  // ---------------------------------------------------------------
  // up to 16 bytes collected; later ones overwrite
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= 16'h0000;
    end else if (start_ev || commit) begin
      mask_r <= 16'h0000; // Repeated start abandons the page
    end else if (data_we) begin
      mask_r[cnt_r[3:0]] <= 1'b1;
    end
  end

  always_ff @(posedge link_clk) begin
    if (data_we) begin
      pbuf[cnt_r[3:0]] <= byte_in;
    end
  end

  // array updated at the stop, one page row
  always_ff @(posedge link_clk) begin
    if (commit) begin
      for (int i = 0; i < EE_PAGE_B; i++) begin
        if (mask_r[i]) begin
          mem[{cnt_r[10:4], 4'(i)}] <= pbuf[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Write-cycle crossing and timer
  // ---------------------------------------------------------------
  // busy from stop until timer end toggles back
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      wbusy_r  <= 1'b0;
      wr_tgl_r <= 1'b0;
      done_q   <= 3'h0;
    end else begin
      done_q <= {done_q[1:0], done_tgl_r};
      if (commit) begin
        wbusy_r  <= 1'b1;
        wr_tgl_r <= ~wr_tgl_r;
      end else if (done_q[2] ^ done_q[1]) begin
        wbusy_r <= 1'b0;
      end
    end
  end

  // Timer on the system clock; the count is a parameter to allow short sims
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      req_q      <= 3'h0;
      tmr_run_r  <= 1'b0;
      tmr_r      <= 20'h0_0000;
      done_tgl_r <= 1'b0;
    end else begin
      req_q <= {req_q[1:0], wr_tgl_r};
      if (req_q[2] ^ req_q[1]) begin
        tmr_run_r <= 1'b1;
        tmr_r     <= 20'h0_0000;
      end else if (tmr_run_r && tmr_r == 20'(WR_CYCLES - 1)) begin
        tmr_run_r  <= 1'b0;
        done_tgl_r <= ~done_tgl_r;
      end else if (tmr_run_r) begin
        tmr_r <= tmr_r + 20'h0_0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Status outputs
  // ---------------------------------------------------------------
  // standby at reset and when idle with no write pending
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      standby    <= 1'b1;
      write_busy <= 1'b0;
    end else begin
      standby    <= (st_r == EE_D_IDLE) && !wbusy_r;
      write_busy <= wbusy_r;
    end
  end

endmodule

// *** src/ee_master.sv ***
// Bus master end: makes SCL by dividing its clock and runs write, random
// read, current read and bus recovery sequences for a user command port.
// Assumes one open-drain device on the link and a 25 MHz clock.
module ee_master
  import ee_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  rst_n,
  ee_link_if.master  link,
  input  wire logic  cmd_valid,
  output logic       cmd_ready,
  input  ee_op_t     cmd_op,
  input  wire logic [10:0] cmd_addr,
  input  wire logic [3:0]  cmd_len,
  input  wire logic [7:0]  cmd_wdata,
  output logic       wd_take,
  output logic       rd_valid,
  output logic [7:0] rd_data,
  output logic       done,
  output logic       nack
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [1:0]  sda_q;
  ee_mst_t     st_r;
  ee_op_t      op_r;
  logic [10:0] addr_r;
  logic [7:0]  wbyte_r;
  logic [3:0]  left_r;
  logic [2:0]  step_r;
  logic [3:0]  bit_r;
  logic [1:0]  q_r;
  logic [3:0]  qc_r;
  logic        scl_r;
  logic        oe_r;
  logic        tick;
  logic        rep;
  logic        oe_nxt;
  ee_sym_t     kind;
  logic [7:0]  txb;

  // ---------------------------------------------------------------
  // Sequence table
  // ---------------------------------------------------------------
  // symbol order per operation
  always_comb begin
    kind = EE_SYM_STOP;
    txb  = 8'h00;
    case (op_r)
      EE_OP_WRITE: begin
        case (step_r)
          3'h0: kind = EE_SYM_START;
          3'h1: begin kind = EE_SYM_TX; txb = {EE_DEV_CODE, addr_r[10:8], 1'b0}; end
          3'h2: begin kind = EE_SYM_TX; txb = addr_r[7:0]; end
          3'h3: begin kind = EE_SYM_TX; txb = wbyte_r; end
          default: kind = EE_SYM_STOP;
        endcase
      end
      EE_OP_RAND_RD: begin
        case (step_r)
          3'h0: kind = EE_SYM_START;
          3'h1: begin kind = EE_SYM_TX; txb = {EE_DEV_CODE, addr_r[10:8], 1'b0}; end
          3'h2: begin kind = EE_SYM_TX; txb = addr_r[7:0]; end
          3'h3: kind = EE_SYM_START;
          3'h4: begin kind = EE_SYM_TX; txb = {EE_DEV_CODE, addr_r[10:8], 1'b1}; end
          3'h5: kind = EE_SYM_RX;
          default: kind = EE_SYM_STOP;
        endcase
      end
      EE_OP_CUR_RD: begin
        case (step_r)
          3'h0: kind = EE_SYM_START;
          3'h1: begin kind = EE_SYM_TX; txb = {EE_DEV_CODE, addr_r[10:8], 1'b1}; end
          3'h2: kind = EE_SYM_RX;
          default: kind = EE_SYM_STOP;
        endcase
      end
      default: begin
        case (step_r)
          3'h0: kind = EE_SYM_RECOV;
          3'h1: kind = EE_SYM_START;
          default: kind = EE_SYM_STOP;
        endcase
      end
    endcase
    // An unacknowledged byte ends the command with a stop, once its ninth
    // clock is over; switching earlier would skip the stop on the bus
    if (nack && bit_r != EE_LAST_BIT) begin
      kind = EE_SYM_STOP;
    end
  end

  assign tick = (st_r == EE_M_RUN) && (qc_r == EE_QTR_LAST);
  // data byte repeats while bytes remain
  assign rep  = (kind == EE_SYM_RX) || (op_r == EE_OP_WRITE && step_r == 3'h3);

  // SDA levels per quarter; SCL is high in quarters 2 and 3 only
  always_comb begin
    case (kind)
      EE_SYM_START: oe_nxt = (q_r == 2'h3);
      EE_SYM_STOP:  oe_nxt = (q_r == 2'h1) || (q_r == 2'h2);
      EE_SYM_TX:    oe_nxt = (bit_r != EE_LAST_BIT) && !txb[3'(4'h7 - bit_r)];
      EE_SYM_RX:    oe_nxt = (bit_r == EE_LAST_BIT) && (left_r != 4'h0);
      default:      oe_nxt = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sda_q <= EE_SYNC_IDLE;
    end else begin
      sda_q <= {sda_q[0], link.sda};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r    <= EE_M_IDLE;
      op_r    <= EE_OP_WRITE;
      addr_r  <= 11'h000;
      wbyte_r <= 8'h00;
      left_r  <= 4'h0;
      step_r  <= 3'h0;
      bit_r   <= 4'h0;
      q_r     <= 2'h0;
      qc_r    <= 4'h0;
      nack    <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      case (st_r)
        EE_M_IDLE: begin
          if (cmd_valid) begin
            st_r    <= EE_M_RUN;
            op_r    <= cmd_op;
            addr_r  <= cmd_addr;
            wbyte_r <= cmd_wdata;
            left_r  <= cmd_len;
            step_r  <= 3'h0;
            bit_r   <= 4'h0;
            q_r     <= 2'h0;
            qc_r    <= 4'h0;
            nack    <= 1'b0;
          end
        end
        EE_M_RUN: begin
          qc_r <= tick ? 4'h0 : qc_r + 4'h1;
          // Sample at the end of quarter 2, mid-way through the high phase, after the synchroniser
          if (tick && q_r == 2'h2 && kind == EE_SYM_TX && bit_r == EE_LAST_BIT) begin
            nack <= sda_q[1];
          end
          if (tick && q_r == 2'h2 && kind == EE_SYM_RX && bit_r != EE_LAST_BIT) begin
            rd_data <= {rd_data[6:0], sda_q[1]};
          end
          if (tick) begin
            q_r <= q_r + 2'h1;
          end
          if (tick && q_r == 2'h3) begin
            if (kind == EE_SYM_STOP) begin
              st_r <= EE_M_DONE;
            end else if (kind != EE_SYM_START && bit_r != EE_LAST_BIT) begin
              bit_r <= bit_r + 4'h1;
            end else if (kind != EE_SYM_START && rep && left_r != 4'h0) begin
              bit_r   <= 4'h0;
              left_r  <= left_r - 4'h1;
              wbyte_r <= cmd_wdata;
            end else begin
              bit_r  <= 4'h0;
              step_r <= step_r + 3'h1;
            end
          end
        end
        default: st_r <= EE_M_IDLE;
      endcase
    end
  end

  // SDA updates only from quarter 1, while SCL is already low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_r <= 1'b1;
      oe_r  <= 1'b0;
    end else if (st_r == EE_M_RUN) begin
      scl_r <= q_r[1];
      if (q_r != 2'h0) begin
        oe_r <= oe_nxt;
      end
    end else begin
      scl_r <= 1'b1;
      oe_r  <= 1'b0;
    end
  end

  // Strobes for the user side
  assign cmd_ready = (st_r == EE_M_IDLE);
  assign done      = (st_r == EE_M_DONE);
  assign rd_valid  = tick && q_r == 2'h3 && kind == EE_SYM_RX && bit_r == EE_LAST_BIT;
  assign wd_take   = tick && q_r == 2'h3 && kind == EE_SYM_TX && rep
                     && bit_r == EE_LAST_BIT && left_r != 4'h0 && !nack;
  assign link.scl      = scl_r;
  assign link.sda_m_oe = oe_r;
  assign link.sda_m_o  = 1'b0;

endmodule

// *** verification/ee_link_props.sv ***
// Checker for the two-wire link between the master and device ends.
// Assumes it sits beside the shared link interface and sees both clocks.
module ee_link_props #(
  parameter int WR_CYCLES = 50
) (
  input wire logic clock,
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic wp,
  input wire logic write_busy,
  input wire logic standby
);
  // ---------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------
  // Crossing adds a few cycles, so the bounds leave some slack
  localparam int BUSY_MIN = WR_CYCLES - 2;
  localparam int BUSY_MAX = WR_CYCLES + 6;
  logic [15:0] busy_cnt_r;

  // Length of the current write cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) busy_cnt_r <= 16'h0000;
    else if (write_busy) busy_cnt_r <= busy_cnt_r + 16'h0001;
    else busy_cnt_r <= 16'h0000;
  end

  sequence scl_was_low;
    !$past(scl) && !$past(scl, 2);
  endsequence

  sequence bus_idle;
    scl && sda;
  endsequence

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  dev_od_low_a:
    assert property (@(posedge link_clk) disable iff (!rst_n) sda_d_oe |-> !sda_d_o)
    else $error("device drives sda high");
  dev_sda_hold_a:
    assert property (@(posedge link_clk) disable iff (!rst_n)
      scl && $past(scl) |-> $stable(sda_d_oe)) else $error("device moved sda, scl high");
  dev_launch_a:
    assert property (@(posedge link_clk) disable iff (!rst_n)
      $changed(sda_d_oe) |-> scl_was_low) else $error("device moved sda near scl edge");
  dev_standby_a:
    assert property (@(posedge link_clk) disable iff (!rst_n) standby |-> !sda_d_oe)
    else $error("device drives sda in standby");
  busy_quiet_a:
    assert property (@(posedge clock) disable iff (!rst_n) write_busy |-> !sda_d_oe)
    else $error("device answers during write cycle");
  busy_len_a:
    assert property (@(posedge clock) disable iff (!rst_n)
      $past(rst_n) && $fell(write_busy) |-> $past(busy_cnt_r) >= 16'(BUSY_MIN))
    else $error("write cycle too short");
  busy_max_a:
    assert property (@(posedge clock) disable iff (!rst_n) busy_cnt_r <= 16'(BUSY_MAX))
    else $error("write cycle too long");
  wp_block_a:
    assert property (@(posedge clock) disable iff (!rst_n)
      wp && $past(wp, 4) |-> !$rose(write_busy)) else $error("write cycle while protected");
  stop_launch_a:
    assert property (@(posedge clock) disable iff (!rst_n) $rose(write_busy) |-> bus_idle)
    else $error("write cycle began before stop");
endmodule

// *** verification/i2c_serial_eeprom_16kbit_tb.sv ***
// Self-checking bench: master end and device end joined by one link.
// Assumes the master makes SCL; the bench drives both clocks, the command port, wp and rst_n only.
module i2c_serial_eeprom_16kbit_tb
  import ee_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // Long enough that a poll right after a write still meets it
  localparam int WRC = 400;
  localparam int TMO = 40000;
  logic       clock = 1'b0;
  logic       link_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       wp = 1'b0;
  logic       cmd_valid = 1'b0;
  ee_op_t     cmd_op = EE_OP_WRITE;
  logic [10:0] cmd_addr = 11'h000;
  logic [3:0] cmd_len = 4'h0;
  logic [7:0] cmd_wdata = 8'h00;
  logic       cmd_ready, wd_take, rd_valid, done, nack, standby, write_busy;
  logic [7:0] rd_data;
  logic [7:0] wbuf [16];
  logic [7:0] rbuf [$];
  int         widx = 0;
  int         cyc = 0;
  int         fail_count = 0;
  int         checks = 0;

  // ---------------------------------------------------------------
  // Clocks, link and ends
  // ---------------------------------------------------------------
  always #20 clock = ~clock;
  initial begin
    #2.5;
    forever #6 link_clk = ~link_clk;
  end

  ee_link_if link();
  ee_device #(.WR_CYCLES(WRC)) ee_device_inst (.link_clk(link_clk), .clock(clock),
    .rst_n(rst_n), .link(link), .wp(wp), .standby(standby), .write_busy(write_busy));
  ee_master ee_master_inst (.clock(clock), .rst_n(rst_n), .link(link),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .cmd_wdata(cmd_wdata), .wd_take(wd_take), .rd_valid(rd_valid),
    .rd_data(rd_data), .done(done), .nack(nack));
  ee_link_props #(.WR_CYCLES(WRC)) ee_link_props_inst (.clock(clock),
    .link_clk(link_clk), .rst_n(rst_n), .scl(link.scl), .sda(link.sda),
    .sda_d_o(link.sda_d_o), .sda_d_oe(link.sda_d_oe), .wp(wp),
    .write_busy(write_busy), .standby(standby));

  // Byte feed, read capture and hang guard
  always @(posedge clock) begin
    if (wd_take === 1'b1) widx <= widx + 1;
    if (rd_valid === 1'b1) rbuf.push_back(rd_data);
    cyc <= cyc + 1;
    if (cyc == TMO) begin
      fail_count++;
      close_out();
    end
  end
  always @(negedge clock) cmd_wdata <= wbuf[widx[3:0]];

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One command, waited on up to its done pulse
  task automatic cmd(input ee_op_t op, input logic [10:0] a, input logic [3:0] n);
    int k;
    @(negedge clock);
    rbuf.delete();
    cmd_op = op;
    cmd_addr = a;
    cmd_len = n;
    cmd_valid = 1'b1;
    for (k = 0; k < 50 && cmd_ready !== 1'b1; k++) @(negedge clock);
    @(negedge clock);
    cmd_valid = 1'b0;
    widx = 1;
    for (k = 0; k < 9000 && done !== 1'b1; k++) @(negedge clock);
    chk({7'h00, done}, 8'h01);
    widx = 0;
  endtask

  // Whether a write cycle starts, then its end
  task automatic wait_write(input logic exp);
    int k;
    logic seen;
    seen = 1'b0;
    for (k = 0; k < 20; k++) begin
      @(negedge clock);
      seen = seen | (write_busy === 1'b1);
    end
    chk({7'h00, seen}, {7'h00, exp});
    for (k = 0; k < 2000 && write_busy !== 1'b0; k++) @(negedge clock);
  endtask

  task automatic rd2(input ee_op_t op, input logic [10:0] a, input logic [3:0] n,
                     input logic [7:0] e0, input logic [7:0] e1);
    cmd(op, a, n);
    chk({7'h00, nack}, 8'h00);
    chk(8'(rbuf.size()), 8'(n) + 8'h01);
    chk(rbuf[0], e0);
    if (n != 4'h0) chk(rbuf[1], e1);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_byte();
    wbuf[0] = 8'h3c;
    cmd(EE_OP_WRITE, 11'h5a3, 4'h0);
    chk({7'h00, nack}, 8'h00);
    wait_write(1'b1);
    rd2(EE_OP_RAND_RD, 11'h5a3, 4'h0, 8'h3c, 8'h00);
    $display("test byte write done");
  endtask

  // Four bytes from two short of the page end: last two wrap in page
  task automatic t_page();
    for (int k = 0; k < 4; k++) wbuf[k] = 8'(8'h11 * (k + 1));
    cmd(EE_OP_WRITE, 11'h20e, 4'h3);
    wait_write(1'b1);
    rd2(EE_OP_RAND_RD, 11'h20e, 4'h1, 8'h11, 8'h22);
    rd2(EE_OP_RAND_RD, 11'h200, 4'h0, 8'h33, 8'h00);
    rd2(EE_OP_CUR_RD, 11'h200, 4'h0, 8'h44, 8'h00);
    $display("test page write done");
  endtask

  task automatic t_poll();
    wbuf[0] = 8'h5a;
    cmd(EE_OP_WRITE, 11'h100, 4'h0);
    cmd(EE_OP_CUR_RD, 11'h100, 4'h0);
    chk({7'h00, nack}, 8'h01);
    wait_write(1'b1);
    rd2(EE_OP_RAND_RD, 11'h100, 4'h0, 8'h5a, 8'h00);
    $display("test polling done");
  endtask

  task automatic t_wp();
    wp = 1'b1;
    wbuf[0] = 8'ha5;
    cmd(EE_OP_WRITE, 11'h100, 4'h0);
    chk({7'h00, nack}, 8'h00);
    wait_write(1'b0);
    wp = 1'b0;
    rd2(EE_OP_RAND_RD, 11'h100, 4'h0, 8'h5a, 8'h00);
    $display("test write protect done");
  endtask

  task automatic t_wrap();
    wbuf[0] = 8'he1;
    cmd(EE_OP_WRITE, 11'h7ff, 4'h0);
    wait_write(1'b1);
    wbuf[0] = 8'he2;
    cmd(EE_OP_WRITE, 11'h000, 4'h0);
    wait_write(1'b1);
    rd2(EE_OP_RAND_RD, 11'h7ff, 4'h1, 8'he1, 8'he2);
    $display("test array wrap done");
  endtask

  task automatic t_recover();
    cmd(EE_OP_RECOVER, 11'h000, 4'h0);
    rd2(EE_OP_RAND_RD, 11'h000, 4'h0, 8'he2, 8'h00);
    repeat (4) @(negedge clock);
    chk({7'h00, standby}, 8'h01);
    $display("test recovery done");
  endtask

  // Reset for two cycles, then every scenario in turn
  initial begin
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    repeat (2) @(negedge clock);
    chk({7'h00, standby}, 8'h01);
    t_byte();
    t_page();
    t_poll();
    t_wp();
    t_wrap();
    t_recover();
    close_out();
  end
endmodule
